// ===== hdl/mem_bus_unit.sv
// Memory and external bus interface unit: on-chip RAM, control registers,
// external cycles with ready, global bus request and bus release.
// Assumes core-side inputs are on clk_i and requests are held until done_o.
`timescale 1ns/1ns
module mem_bus_unit
  import mem_bus_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Core request
  input  wire logic              req_i,
  input  wire logic [1:0]        space_i,
  input  wire logic              we_i,
  input  wire logic              dir_i,
  input  wire logic [AW-1:0]     addr_i,
  input  wire logic [PAGE_W-1:0] page_i,
  input  wire logic [OFS_W-1:0]  offset_i,
  input  wire logic [DW-1:0]     wdata_i,
  output logic                   done_o,
  output logic      [DW-1:0]     rdata_o,
  // Core control
  input  wire logic              rpt_i,
  input  wire logic              irq_pending_i,
  input  wire logic              map_block_zero_data_i,
  input  wire logic              map_block_zero_program_i,
  output logic                   irq_take_o,
  output logic                   block_zero_prog_o,
  // External bus
  output logic      [AW-1:0]     ext_addr_o,
  output logic      [DW-1:0]     ext_data_o,
  input  wire logic [DW-1:0]     ext_data_i,
  output logic                   ext_data_oe_b_o,
  output logic                   ext_ctrl_oe_b_o,
  output logic                   prog_strobe_b_o,
  output logic                   data_strobe_b_o,
  output logic                   io_strobe_b_o,
  output logic                   read_o,
  input  wire logic              ready_i,
  // Global bus and release
  output logic                   bus_request_out_o,
  input  wire logic              bus_release_req_b_i,
  output logic                   bus_release_grant_b_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic          ready_s;
  logic          hold_b_s;
  logic [DW-1:0] data_s;

  pin_sync #(.WIDTH(1), .INIT(1'b0)) u_ready_sync (.clk_i(clk_i), .rst_b_i(rst_b_i), .d_i(ready_i), .q_o(ready_s));
  pin_sync #(.WIDTH(1), .INIT(1'b1)) u_hold_sync (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .d_i(bus_release_req_b_i), .q_o(hold_b_s));
  // Data settles with ready, so both are delayed alike
  pin_sync #(.WIDTH(DW), .INIT(16'h0000)) u_data_sync (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .d_i(ext_data_i), .q_o(data_s));

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_type         state_r,   state_nxt;
  logic              done_r,    done_nxt;
  logic [DW-1:0]     rdata_r,   rdata_nxt;
  logic              irq_r,     irq_nxt;
  logic              bzp_r,     bzp_nxt;
  logic [AW-1:0]     eaddr_r,   eaddr_nxt;
  logic [DW-1:0]     edata_r,   edata_nxt;
  logic              doe_b_r,   doe_b_nxt;
  logic              coe_b_r,   coe_b_nxt;
  logic              ps_b_r,    ps_b_nxt;
  logic              ds_b_r,    ds_b_nxt;
  logic              is_b_r,    is_b_nxt;
  logic              rd_r,      rd_nxt;
  logic              br_r,      br_nxt;
  logic              grant_b_r, grant_b_nxt;
  logic [GWIN_W-1:0] gwin_r,    gwin_nxt;
  logic [DW-1:0]     mmr_r   [0:MMR_PLAIN-1];
  logic [DW-1:0]     mmr_nxt [0:MMR_PLAIN-1];

  // ----------------------------------------
  // Address formation and decode
  // ----------------------------------------
  logic [AW-1:0] addr;
  tgt_type       tgt;
  logic          go;
  logic          go_int;
  logic          go_ext;
  logic          in_global;
  logic          busy;
  logic [DW-1:0] bz_q;
  logic [DW-1:0] b1_q;
  logic [DW-1:0] b2_q;
  logic          bz_we;
  logic          b1_we;
  logic          b2_we;

  function automatic tgt_type decode(input logic [1:0] sp, input logic [AW-1:0] a, input logic bzp);
    tgt_type t;
    t = TGT_EXT;
    if (sp == SP_DATA) begin
      if (a <= MMR_LAST) begin
        t = TGT_MMR;
      end else if (a >= B2_BASE && a <= B2_LAST) begin
        t = TGT_B2;
      end else if (a >= B1_BASE && a <= B1_LAST) begin
        t = TGT_B1;
      end else if (!bzp && a >= BZ_DATA_BASE && a <= BZ_DATA_LAST) begin
        t = TGT_BZ;
      end
    end else if (sp == SP_PROG && bzp && a >= BZ_PROG_BASE) begin
      t = TGT_BZ;
    end
    return t;
  endfunction

  assign addr      = dir_i ? {page_i, offset_i} : addr_i;
  assign tgt       = decode(space_i, addr, bzp_r);
  assign go        = req_i && !done_r && (state_r != ST_EXT);
  assign go_int    = go && (tgt != TGT_EXT);
  assign go_ext    = go && (tgt == TGT_EXT);
  assign in_global = (space_i == SP_DATA) && (gwin_r != GWIN_RESET) && ((addr[15:8] & gwin_r) == gwin_r);
  assign busy      = (state_r == ST_EXT) || rpt_i || go_ext;
  assign bz_we     = go_int && we_i && (tgt == TGT_BZ);
  assign b1_we     = go_int && we_i && (tgt == TGT_B1);
  assign b2_we     = go_int && we_i && (tgt == TGT_B2);

  // ----------------------------------------
  // On-chip RAM blocks
  // ----------------------------------------
  ram_block #(.DEPTH(BZ_DEPTH), .ABITS(8), .WIDTH(DW)) u_block_zero (.clk_i(clk_i), .we_i(bz_we),
    .addr_i(addr[7:0]), .wdata_i(wdata_i), .rdata_o(bz_q));
  ram_block #(.DEPTH(B1_DEPTH), .ABITS(8), .WIDTH(DW)) u_fixed_data_block_one (.clk_i(clk_i), .we_i(b1_we),
    .addr_i(addr[7:0]), .wdata_i(wdata_i), .rdata_o(b1_q));
  ram_block #(.DEPTH(B2_DEPTH), .ABITS(5), .WIDTH(DW)) u_fixed_data_block_two (.clk_i(clk_i), .we_i(b2_we),
    .addr_i(addr[4:0]), .wdata_i(wdata_i), .rdata_o(b2_q));

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_nxt   = state_r;
    done_nxt    = 1'b0;
    rdata_nxt   = rdata_r;
    bzp_nxt     = bzp_r;
    eaddr_nxt   = eaddr_r;
    edata_nxt   = edata_r;
    doe_b_nxt   = doe_b_r;
    coe_b_nxt   = coe_b_r;
    ps_b_nxt    = ps_b_r;
    ds_b_nxt    = ds_b_r;
    is_b_nxt    = is_b_r;
    rd_nxt      = rd_r;
    br_nxt      = br_r;
    grant_b_nxt = grant_b_r;
    gwin_nxt    = gwin_r;
    for (int i = 0; i < MMR_PLAIN; i++) begin
      mmr_nxt[i] = mmr_r[i];
    end
    irq_nxt = irq_pending_i && !busy;

    if (map_block_zero_program_i) begin
      bzp_nxt = 1'b1;
    end else if (map_block_zero_data_i) begin
      bzp_nxt = 1'b0;
    end

    // On-chip work also runs in hold
    if (go_int) begin
      done_nxt = 1'b1;
      case (tgt)
        TGT_BZ:  rdata_nxt = bz_q;
        TGT_B1:  rdata_nxt = b1_q;
        TGT_B2:  rdata_nxt = b2_q;
        TGT_MMR: begin
          if (addr[2:0] == MMR_GWIN) begin
            rdata_nxt = {8'h00, gwin_r};
            if (we_i) begin
              gwin_nxt = wdata_i[GWIN_W-1:0];
            end
          end else begin
            rdata_nxt = mmr_r[addr[2:0]];
            if (we_i) begin
              mmr_nxt[addr[2:0]] = wdata_i;
            end
          end
        end
        default: rdata_nxt = rdata_r;
      endcase
    end

    case (state_r)
      ST_IDLE: begin
        br_nxt = go_ext && in_global && hold_b_s;
        if (!hold_b_s) begin
          state_nxt = ST_HOLD;
          coe_b_nxt = 1'b1;
          doe_b_nxt = 1'b1;
        end else if (go_ext) begin
          state_nxt = ST_EXT;
          eaddr_nxt = addr;
          edata_nxt = wdata_i;
          rd_nxt    = !we_i;
          doe_b_nxt = !we_i;
          ps_b_nxt  = (space_i != SP_PROG);
          ds_b_nxt  = (space_i != SP_DATA);
          is_b_nxt  = (space_i != SP_IO);
        end
      end
      ST_EXT: begin
        // Wait states end only on ready; other external work waits
        if (ready_s) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
          ps_b_nxt  = 1'b1;
          ds_b_nxt  = 1'b1;
          is_b_nxt  = 1'b1;
          doe_b_nxt = 1'b1;
          rd_nxt    = 1'b1;
          if (rd_r) begin
            rdata_nxt = data_s;
          end
        end
      end
      ST_HOLD: begin
        br_nxt = 1'b0;
        if (hold_b_s) begin
          state_nxt   = ST_IDLE;
          grant_b_nxt = 1'b1;
          coe_b_nxt   = 1'b0;
        end else begin
          grant_b_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r   <= ST_IDLE;
      done_r    <= 1'b0;
      rdata_r   <= 16'h0000;
      irq_r     <= 1'b0;
      bzp_r     <= 1'b0;
      eaddr_r   <= 16'h0000;
      edata_r   <= 16'h0000;
      doe_b_r   <= 1'b1;
      coe_b_r   <= 1'b0;
      ps_b_r    <= 1'b1;
      ds_b_r    <= 1'b1;
      is_b_r    <= 1'b1;
      rd_r      <= 1'b1;
      br_r      <= 1'b0;
      grant_b_r <= 1'b1;
      gwin_r    <= GWIN_RESET;
      for (int i = 0; i < MMR_PLAIN; i++) begin
        mmr_r[i] <= MMR_RESET;
      end
    end else begin
      state_r   <= state_nxt;
      done_r    <= done_nxt;
      rdata_r   <= rdata_nxt;
      irq_r     <= irq_nxt;
      bzp_r     <= bzp_nxt;
      eaddr_r   <= eaddr_nxt;
      edata_r   <= edata_nxt;
      doe_b_r   <= doe_b_nxt;
      coe_b_r   <= coe_b_nxt;
      ps_b_r    <= ps_b_nxt;
      ds_b_r    <= ds_b_nxt;
      is_b_r    <= is_b_nxt;
      rd_r      <= rd_nxt;
      br_r      <= br_nxt;
      grant_b_r <= grant_b_nxt;
      gwin_r    <= gwin_nxt;
      for (int i = 0; i < MMR_PLAIN; i++) begin
        mmr_r[i] <= mmr_nxt[i];
      end
    end
  end

  assign done_o                = done_r;
  assign rdata_o               = rdata_r;
  assign irq_take_o            = irq_r;
  assign block_zero_prog_o     = bzp_r;
  assign ext_addr_o            = eaddr_r;
  assign ext_data_o            = edata_r;
  assign ext_data_oe_b_o       = doe_b_r;
  assign ext_ctrl_oe_b_o       = coe_b_r;
  assign prog_strobe_b_o       = ps_b_r;
  assign data_strobe_b_o       = ds_b_r;
  assign io_strobe_b_o         = is_b_r;
  assign read_o                = rd_r;
  assign bus_request_out_o     = br_r;
  assign bus_release_grant_b_o = grant_b_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_float_then_grant; $fell(bus_release_grant_b_o) |-> ext_ctrl_oe_b_o && $past(ext_ctrl_oe_b_o);
  endproperty
  a_float_then_grant: assert property (p_float_then_grant) else $error("grant before bus floated");
  property p_release_ends; (state_r == ST_HOLD) && hold_b_s |=> bus_release_grant_b_o && !ext_ctrl_oe_b_o;
  endproperty
  a_release_ends: assert property (p_release_ends) else $error("grant not withdrawn");
  property p_internal_one_cycle; go_int |=> done_o; endproperty
  a_internal_one_cycle: assert property (p_internal_one_cycle) else $error("on-chip access stalled");
  property p_wait_ready; (state_r == ST_EXT) && !ready_s |=> !done_o && (state_r == ST_EXT); endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("cycle ended without ready");
  property p_global_request;
    (state_r == ST_IDLE) && hold_b_s && go_ext && in_global |=> bus_request_out_o [*1] ##0 (state_r == ST_EXT);
  endproperty
  a_global_request: assert property (p_global_request) else $error("no bus request for global access");
  property p_request_drops; (state_r == ST_IDLE) && !(go_ext && in_global) |=> !bus_request_out_o; endproperty
  a_request_drops: assert property (p_request_drops) else $error("bus request held too long");
  property p_no_irq_in_cycle; (state_r == ST_EXT) || rpt_i |=> !irq_take_o; endproperty
  a_no_irq_in_cycle: assert property (p_no_irq_in_cycle) else $error("interrupt during multicycle");
  property p_map_program; map_block_zero_program_i |=> block_zero_prog_o; endproperty
  a_map_program: assert property (p_map_program) else $error("block zero not moved");
  property p_direct_address;
    (state_r == ST_IDLE) && hold_b_s && go_ext && dir_i |=> ext_addr_o == {$past(page_i), $past(offset_i)};
  endproperty
  a_direct_address: assert property (p_direct_address) else $error("direct address wrong");

endmodule

// ===== hdl/mem_bus_pkg.sv
// Constants, types and memory map of the memory and bus interface unit.
// Assumes a single 25 MHz clock domain and a core that holds each request until done.
//
// How it works
// - On-chip data RAM is 544 words: two fixed data blocks plus block zero.
// - Map commands switch block zero between data and program space at run time.
// - Program fetches outside on-chip program RAM always go to the external bus.
// - Program, data and I/O are separate spaces; on-chip RAM sits in data or program.
// - On-chip accesses finish in one cycle; even fast external ones wait two cycles for the ready synchroniser.
// - An external cycle stalls until the synchronised ready line is high.
// - I/O cycles use the same pins and sequence as memory, only the strobe differs.
// - Six control registers are decoded at the bottom of data space.
// - The 8-bit global window size register selects the shared global data region.
// - An external data access inside the global window raises the bus request.
// - On release request the bus lines float first, then the grant goes low.
// - On-chip accesses keep running while the external bus is released.
// - Interrupts wait while an external cycle, a repeat or a pending external access runs.
// - Only one external access runs at a time; a second one waits its turn.
// - Direct addressing joins the 9-bit page above the 7-bit offset.

package mem_bus_pkg;

  localparam int AW = 16;
  localparam int DW = 16;
  localparam int PAGE_W = 9;
  localparam int OFS_W = 7;
  localparam int GWIN_W = 8;

  // Address spaces
  localparam logic [1:0] SP_PROG = 2'h0;
  localparam logic [1:0] SP_DATA = 2'h1;
  localparam logic [1:0] SP_IO   = 2'h2;

  // On-chip blocks: 256 + 256 + 32 = 544 words
  localparam int BZ_DEPTH = 256;
  localparam int B1_DEPTH = 256;
  localparam int B2_DEPTH = 32;
  localparam logic [15:0] BZ_DATA_BASE = 16'h0200;
  localparam logic [15:0] BZ_DATA_LAST = 16'h02ff;
  localparam logic [15:0] BZ_PROG_BASE = 16'hff00;
  localparam logic [15:0] B1_BASE      = 16'h0300;
  localparam logic [15:0] B1_LAST      = 16'h03ff;
  localparam logic [15:0] B2_BASE      = 16'h0060;
  localparam logic [15:0] B2_LAST      = 16'h007f;

  // Memory-mapped control registers
  localparam logic [15:0] MMR_LAST   = 16'h0005;
  localparam logic [2:0]  MMR_RX     = 3'h0;
  localparam logic [2:0]  MMR_TX     = 3'h1;
  localparam logic [2:0]  MMR_TIMER  = 3'h2;
  localparam logic [2:0]  MMR_PERIOD = 3'h3;
  localparam logic [2:0]  MMR_IMASK  = 3'h4;
  localparam logic [2:0]  MMR_GWIN   = 3'h5;
  localparam int          MMR_PLAIN  = 5;
  localparam logic [7:0]  GWIN_RESET = 8'h00;
  localparam logic [15:0] MMR_RESET  = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXT  = 2'b01,
    ST_HOLD = 2'b11
  } state_type;

  typedef enum logic [2:0] {
    TGT_EXT = 3'h0,
    TGT_BZ  = 3'h1,
    TGT_B1  = 3'h2,
    TGT_B2  = 3'h3,
    TGT_MMR = 3'h4
  } tgt_type;

endpackage

// ===== hdl/pin_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ns
module pin_sync #(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= INIT;
      q_r    <= INIT;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule

// ===== hdl/ram_block.sv
// One on-chip RAM block with synchronous write and combinational read.
// Assumes the caller registers the read data.
`timescale 1ns/1ns
module ram_block #(
  parameter int DEPTH = 256,
  parameter int ABITS = 8,
  parameter int WIDTH = 16
) (
  // Clock
  input  wire logic             clk_i,
  // Access
  input  wire logic             we_i,
  input  wire logic [ABITS-1:0] addr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [0:DEPTH-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[addr_i];

endmodule

// ===== bench/ext_mem_model.sv
// External program, data and I/O memory with a slow ready line.
// Assumes the bench sets the wait count; unwritten words read as an address pattern.
`timescale 1ns/1ns
module ext_mem_model
  import mem_bus_pkg::*;
(
  // Clock
  input  wire logic          clk_i,
  // Bus from the unit
  input  wire logic [AW-1:0] ext_addr_i,
  input  wire logic [DW-1:0] ext_data_i,
  input  wire logic          ext_ctrl_oe_b_i,
  input  wire logic          prog_strobe_b_i,
  input  wire logic          data_strobe_b_i,
  input  wire logic          io_strobe_b_i,
  input  wire logic          read_i,
  // Settings and answers
  input  wire logic [7:0]    wait_n_i,
  output logic      [DW-1:0] ext_data_o,
  output logic               ready_o
);
  logic [DW-1:0] mem [logic [17:0]];
  logic [7:0]    cnt_r = 8'h00;
  logic          sel;
  logic [1:0]    sp;

  // One set of pins for all spaces; only the strobe tells them apart
  assign sp  = !prog_strobe_b_i ? SP_PROG : (!io_strobe_b_i ? SP_IO : SP_DATA);
  assign sel = !ext_ctrl_oe_b_i && !(prog_strobe_b_i && data_strobe_b_i && io_strobe_b_i);
  initial begin
    ext_data_o = 16'h0000;
    ready_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (sel) begin
      cnt_r <= (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
      if (!read_i) mem[{sp, ext_addr_i}] = ext_data_i;
    end else begin
      cnt_r <= 8'h00;
    end
  end
  // Data toggles while unselected, so a stale word never passes for a fresh one
  always @(negedge clk_i) begin
    ready_o <= sel && (cnt_r >= wait_n_i);
    if (sel && read_i)
      ext_data_o <= mem.exists({sp, ext_addr_i}) ? mem[{sp, ext_addr_i}] : ext_addr_i ^ 16'h5a5a;
    else
      ext_data_o <= ~ext_data_o;
  end
endmodule

// ===== bench/mem_bus_unit_bench.sv
// Self-checking bench for the memory and bus interface unit.
// Assumes the external memory model answers every external cycle.
`timescale 1ns/1ns
module mem_bus_unit_bench;
  import mem_bus_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic              clk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0, dir = 1'b0;
  logic              rpt = 1'b0, irq_p = 1'b0, map_data = 1'b0, map_prog = 1'b0, hold_b = 1'b1;
  logic [1:0]        space = 2'h0;
  logic [AW-1:0]     addr = 16'h0000, ext_addr;
  logic [PAGE_W-1:0] page = 9'h000;
  logic [OFS_W-1:0]  offset = 7'h00;
  logic [DW-1:0]     wdata = 16'h0000, rdata, ext_do, ext_di, rd;
  logic [7:0]        wait_n = 8'h00;
  logic              done, irq_take, bzp, data_oe_b, ctrl_oe_b, p_stb_b, d_stb_b, i_stb_b;
  logic              rd_o, ready, bus_req, grant_b, brs, irqs;
  logic [2:0]        stb;
  int                cyc, err_total = 0, n_tests = 0;

  always #20 clk = ~clk;

  mem_bus_unit u_mem_bus_unit (.clk_i(clk), .rst_b_i(rst_b), .req_i(req), .space_i(space), .we_i(we),
    .dir_i(dir), .addr_i(addr), .page_i(page), .offset_i(offset), .wdata_i(wdata), .done_o(done),
    .rdata_o(rdata), .rpt_i(rpt), .irq_pending_i(irq_p), .map_block_zero_data_i(map_data),
    .map_block_zero_program_i(map_prog), .irq_take_o(irq_take), .block_zero_prog_o(bzp),
    .ext_addr_o(ext_addr), .ext_data_o(ext_do), .ext_data_i(ext_di), .ext_data_oe_b_o(data_oe_b),
    .ext_ctrl_oe_b_o(ctrl_oe_b), .prog_strobe_b_o(p_stb_b), .data_strobe_b_o(d_stb_b),
    .io_strobe_b_o(i_stb_b), .read_o(rd_o), .ready_i(ready), .bus_request_out_o(bus_req),
    .bus_release_req_b_i(hold_b), .bus_release_grant_b_o(grant_b));

  ext_mem_model u_ext_mem_model (.clk_i(clk), .ext_addr_i(ext_addr), .ext_data_i(ext_do),
    .ext_ctrl_oe_b_i(ctrl_oe_b), .prog_strobe_b_i(p_stb_b), .data_strobe_b_i(d_stb_b),
    .io_strobe_b_i(i_stb_b), .read_i(rd_o), .wait_n_i(wait_n), .ext_data_o(ext_di), .ready_o(ready));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One core access; the request is held until done, as the core port demands
  task automatic acc(input logic [1:0] sp, input logic wr, input logic [15:0] a, input logic [15:0] d,
                     input logic dr);
    cyc = 0; stb = 3'h0; brs = 1'b0; irqs = 1'b0;
    @(negedge clk);
    req = 1'b1; space = sp; we = wr; dir = dr; wdata = d; rpt = 1'b0;
    addr = dr ? ~a : a; page = a[15:7]; offset = a[6:0];
    do begin
      @(negedge clk);
      cyc++;
      stb |= ~{i_stb_b, d_stb_b, p_stb_b};
      brs |= bus_req;
      if (done !== 1'b1) irqs |= irq_take;
    end while (done !== 1'b1 && cyc < 300);
    req = 1'b0;
    rd = rdata;
    if (done !== 1'b1) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic xfer(input logic [1:0] sp, input logic [15:0] a, input logic ext);
    logic [15:0] d;
    d = 16'($urandom);
    wait_n = 8'($urandom_range(7));
    acc(sp, 1'b1, a, d, 1'b0);
    acc(sp, 1'b0, a, 16'h0000, 1'b0);
    chk("read data", rd, d);
    chk("strobes", stb, ext ? 3'h1 << sp : 3'h0);
    chk("cycles", ext ? cyc >= wait_n + 2 : cyc == 1, 1'b1);
  endtask

  task automatic map_pulse(input logic p, input logic d);
    @(negedge clk);
    map_prog = p; map_data = d;
    @(negedge clk);
    map_prog = 1'b0; map_data = 1'b0;
    @(negedge clk);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [15:0] a, d;
    logic        fl;
    int          k;
    void'($urandom(35));
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk("grant idle", grant_b, 1'b1);
    chk("block zero map", bzp, 1'b0);
    for (int i = 0; i < 6; i++) begin
      acc(SP_DATA, 1'b0, 16'(i), 16'h0000, 1'b0);
      chk("control reg reset", rd, 32'h0);
      d = 16'($urandom);
      acc(SP_DATA, 1'b1, 16'(i), d, 1'b0);
      acc(SP_DATA, 1'b0, 16'(i), 16'h0000, 1'b0);
      chk("control reg", rd, (i == 5) ? {8'h00, d[7:0]} : d);
    end
    acc(SP_DATA, 1'b1, 16'h0005, 16'h0000, 1'b0);
    $display("test control registers finished");
    for (int i = 0; i < 12; i++) begin
      case (i % 3)
        0: a = B2_BASE + 16'($urandom_range(B2_DEPTH - 1));
        1: a = B1_BASE + 16'($urandom_range(B1_DEPTH - 1));
        default: a = BZ_DATA_BASE + 16'($urandom_range(BZ_DEPTH - 1));
      endcase
      xfer(SP_DATA, a, 1'b0);
    end
    // Two on-chip and two external targets, so the direct address also reaches the pins
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? B1_BASE + 16'($urandom_range(B1_DEPTH - 1)) : {1'b1, 15'($urandom)};
      d = 16'($urandom);
      acc(SP_DATA, 1'b1, a, d, 1'b1);
      acc(SP_DATA, 1'b0, a, 16'h0000, 1'b0);
      chk("direct address", rd, d);
    end
    $display("test on-chip finished");
    for (int i = 0; i < 12; i++) xfer(2'($urandom_range(2)), {1'b1, 15'($urandom)}, 1'b1);
    $display("test external finished");
    map_pulse(1'b1, 1'b0);
    chk("block zero program", bzp, 1'b1);
    xfer(SP_PROG, BZ_PROG_BASE + 16'($urandom_range(255)), 1'b0);
    xfer(SP_DATA, BZ_DATA_BASE + 16'h0040, 1'b1);
    xfer(SP_DATA, B1_BASE + 16'h0011, 1'b0);
    xfer(SP_PROG, 16'h1000, 1'b1);
    map_pulse(1'b0, 1'b1);
    chk("block zero data", bzp, 1'b0);
    xfer(SP_PROG, BZ_PROG_BASE, 1'b1);
    xfer(SP_DATA, BZ_DATA_BASE, 1'b0);
    map_pulse(1'b1, 1'b1);
    chk("program wins", bzp, 1'b1);
    map_pulse(1'b0, 1'b1);
    $display("test memory map finished");
    for (int i = 0; i < 3; i++) begin
      acc(SP_DATA, 1'b1, 16'h0005, (i == 2) ? 16'h0000 : 16'h00f0, 1'b0);
      // Two wait states for the global window reads; the memory model's ready ignores the bus request
      wait_n = 8'h02;
      acc(SP_DATA, 1'b0, (i == 1) ? 16'h1234 : 16'hf012, 16'h0000, 1'b0);
      chk("bus request", brs, i == 0);
      repeat (2) @(negedge clk);
      chk("bus request after", bus_req, 1'b0);
    end
    $display("test global window finished");
    hold_b = 1'b0;
    k = 0; fl = 1'b0;
    while (grant_b !== 1'b0 && k < 20) begin
      fl = ctrl_oe_b;
      @(negedge clk);
      k++;
    end
    chk("grant", grant_b, 1'b0);
    chk("float before grant", fl, 1'b1);
    chk("data float", data_oe_b, 1'b1);
    acc(SP_DATA, 1'b0, B2_BASE + 16'h0003, 16'h0000, 1'b0);
    chk("on-chip in hold", {stb, cyc == 1}, 4'h1);
    hold_b = 1'b1;
    k = 0;
    while (grant_b !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk("grant ended", {grant_b, ctrl_oe_b}, 2'h2);
    $display("test bus release finished");
    irq_p = 1'b1; rpt = 1'b1;
    repeat (4) @(negedge clk);
    chk("irq in repeat", irq_take, 1'b0);
    wait_n = 8'h05;
    acc(SP_IO, 1'b0, 16'h0042, 16'h0000, 1'b0);
    chk("irq in wait", irqs, 1'b0);
    chk("unwritten io", rd, 16'h0042 ^ 16'h5a5a);
    repeat (3) @(negedge clk);
    chk("irq taken", irq_take, 1'b1);
    irq_p = 1'b0;
    $display("test interrupt gating finished");
    summarize();
  end
endmodule
